// >>> rtl/ppc_pkg.sv
// Purpose: shared constants and types of the profile-position command block
// Assumes: 25 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   all offsets, bit positions and tick figures live here
package ppc_pkg;

    // clock and tick figures
    localparam int CLK_HZ        = 25_000_000;
    localparam int TICK_NS       = 1_000_000;     // application tick, 1 ms
    localparam int CUR_PERIOD_PS = 62_500_000;    // current loop, 62.5 us
    localparam int VEL_PERIOD_NS = 250_000;       // velocity loop, 250 us
    localparam int TICK_CYC      = TICK_NS / 40;  // 40 ns clock period
    localparam int CUR_CYC       = CUR_PERIOD_PS / 40_000;
    localparam int VEL_CYC       = VEL_PERIOD_NS / 40;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STAT    = 8'h04;
    localparam logic [7:0] OFF_MODE    = 8'h08;
    localparam logic [7:0] OFF_TARGET  = 8'h0C;
    localparam logic [7:0] OFF_OPTION  = 8'h10;
    localparam logic [7:0] OFF_LIMLO   = 8'h14;
    localparam logic [7:0] OFF_LIMHI   = 8'h18;
    localparam logic [7:0] OFF_ACTPOS  = 8'h1C;
    localparam logic [7:0] OFF_WINDOW  = 8'h20;
    localparam logic [7:0] OFF_FERR    = 8'h24;
    localparam logic [7:0] OFF_DEMAND  = 8'h28;
    localparam logic [7:0] OFF_STATUS2 = 8'h2C;

    // control word bits
    localparam int CB_START  = 4;
    localparam int CB_IMMED  = 5;
    localparam int CB_REL    = 6;
    localparam int CB_HALT   = 8;
    localparam int CB_PASS   = 9;
    // status word bits
    localparam int SB_REACH  = 10;
    localparam int SB_LIMIT  = 11;
    localparam int SB_ACK    = 12;
    localparam int SB_FOLLOW = 13;
    // positioning option bits
    localparam int PO_REF0   = 0;
    localparam int PO_REF1   = 1;
    localparam int PO_AUTO0  = 4;
    localparam int PO_AUTO1  = 5;
    // misc
    localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [15:0] CTRL_RST   = 16'h0000;

    // one queued or active travel command
    typedef struct packed {
        logic        valid;
        logic        pass;    // pass bit from control bit 9; carried along but has no effect
        logic [31:0] target;  // absolute target
    } ppc_cmd_t;

    // motion phase
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_MOVE = 3'b010,
        PH_HALT = 3'b100
    } ppc_phase_t;

endpackage : ppc_pkg

// >>> rtl/ppc_core.sv
// Purpose: profile-position command handshake with AXI4-Lite registers
// Assumes: actual position and following error are written by software or
//          a motion engine through registers; a one-tick jump of demand to the
//          target stands in for the trajectory generator
// Notes:   every status decision happens on the 1 ms strobe
`timescale 1ns/100ps

module ppc_core
    import ppc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int SETTLE_TICKS = 4,
    parameter int FERR_TICKS   = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // loop strobes and application tick
    output logic             tick_1ms,
    output logic             cur_strobe,
    output logic             vel_strobe
);

    // register state
    logic [15:0] ctrl_r;
    logic [15:0] stat_r;
    logic [7:0]  mode_r;
    logic [31:0] target_r, option_r, limlo_r, limhi_r, actpos_r;
    logic [31:0] window_r, ferr_r, demand_r;
    logic [31:0] ferr_win_r;
    // sampled once per tick
    logic [15:0] ctrl_smp_r, ctrl_prev_r;
    logic        in_mode_prev_r;
    ppc_cmd_t    act_r, que_r;
    ppc_phase_t  phase_r;
    logic [31:0] last_tgt_r;
    logic [15:0] settle_r, ferr_cnt_r;
    logic        self_clr_r;
    // a queued command's ack falls when the queue drains, or earlier if bit 4 drops
    logic        ack_q_r;

    // tick and loop strobe counters
    logic [$clog2(TICK_CYCLES)-1:0] tcnt_r;
    logic [$clog2(VEL_CYC)-1:0]     vcnt_r;
    logic [$clog2(CUR_CYC)-1:0]     ccnt_r;
    wire tick_w = (tcnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
    wire vel_w  = (vcnt_r == ($clog2(VEL_CYC))'(VEL_CYC - 1));
    wire cur_w  = (ccnt_r == ($clog2(CUR_CYC))'(CUR_CYC - 1));

    // free-running dividers; loops run faster than the application tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= '0;
            vcnt_r <= '0;
            ccnt_r <= '0;
            tick_1ms <= 1'b0;
            vel_strobe <= 1'b0;
            cur_strobe <= 1'b0;
        end else begin
            tcnt_r <= tick_w ? '0 : tcnt_r + 1'b1;
            vcnt_r <= vel_w ? '0 : vcnt_r + 1'b1;
            ccnt_r <= cur_w ? '0 : ccnt_r + 1'b1;
            tick_1ms <= tick_w;
            vel_strobe <= vel_w;
            cur_strobe <= cur_w;
        end
    end

    // axi4-lite write side: address and data taken in either order
    logic        aw_have_r, w_have_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    wire do_wr = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire wr_hit = (aw_addr_r[7:2] <= OFF_STATUS2[7:2]) & (aw_addr_r != OFF_STAT)
                  & (aw_addr_r != OFF_DEMAND) & (aw_addr_r != OFF_STATUS2);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        for (int i = 0; i < 4; i++)
            if (s[i]) old[i*8 +: 8] = d[i*8 +: 8];
        return old;
    endfunction : merge

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready;
            s_axi_wready  <= ~w_have_r & ~s_axi_wready;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read side: one-cycle registered answer
    wire [31:0] rd_mux =
        (s_axi_araddr == OFF_CTRL)    ? {16'h0000, ctrl_r} :
        (s_axi_araddr == OFF_STAT)    ? {16'h0000, stat_r} :
        (s_axi_araddr == OFF_MODE)    ? {24'h000000, mode_r} :
        (s_axi_araddr == OFF_TARGET)  ? target_r :
        (s_axi_araddr == OFF_OPTION)  ? option_r :
        (s_axi_araddr == OFF_LIMLO)   ? limlo_r :
        (s_axi_araddr == OFF_LIMHI)   ? limhi_r :
        (s_axi_araddr == OFF_ACTPOS)  ? actpos_r :
        (s_axi_araddr == OFF_WINDOW)  ? window_r :
        (s_axi_araddr == OFF_FERR)    ? ferr_r :
        (s_axi_araddr == OFF_DEMAND)  ? demand_r :
        (s_axi_araddr == OFF_STATUS2) ? {29'h0, phase_r} : 32'h00000000;
    wire rd_hit = (s_axi_araddr[1:0] == 2'b00) &
                  (s_axi_araddr <= OFF_STATUS2);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // narrow registers merge on a full word and keep their low bits
    wire [31:0] ctrl_mrg = merge({16'h0000, ctrl_r}, w_data_r, w_strb_r);
    wire [31:0] mode_mrg = merge({24'h000000, mode_r}, w_data_r, w_strb_r);

    // software-written objects; ctrl bit 4 may be cleared by the device
    wire wr_ctrl = do_wr & (aw_addr_r == OFF_CTRL);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r   <= CTRL_RST;
            mode_r   <= '0;
            target_r <= '0;
            option_r <= '0;
            limlo_r  <= 32'h80000000;
            limhi_r  <= 32'h7FFFFFFF;
            actpos_r <= '0;
            window_r <= '0;
            ferr_r   <= '0;
            ferr_win_r <= 32'hFFFFFFFF;
        end else begin
            if (wr_ctrl)
                ctrl_r <= ctrl_mrg[15:0];
            else if (self_clr_r)
                ctrl_r[CB_START] <= 1'b0;
            if (do_wr & (aw_addr_r == OFF_MODE))
                mode_r <= mode_mrg[7:0];
            if (do_wr & (aw_addr_r == OFF_TARGET))
                target_r <= merge(target_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_OPTION))
                option_r <= merge(option_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_LIMLO))
                limlo_r <= merge(limlo_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_LIMHI))
                limhi_r <= merge(limhi_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_ACTPOS))
                actpos_r <= merge(actpos_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_WINDOW))
                window_r <= merge(window_r, w_data_r, w_strb_r);
            if (do_wr & (aw_addr_r == OFF_FERR))
                ferr_r <= merge(ferr_r, w_data_r, w_strb_r);
        end
    end

    // tick-level decoding of the sampled control word
    wire in_mode  = (mode_r == MODE_PROFILE_POS);
    wire start_rise = ctrl_smp_r[CB_START] &
                      (~ctrl_prev_r[CB_START] | ~in_mode_prev_r);
    wire halt_on  = ctrl_smp_r[CB_HALT];
    wire immed    = ctrl_smp_r[CB_IMMED];
    wire rel_base_act = option_r[PO_REF0] | option_r[PO_REF1];
    // relative base: last target, or the actual position register as it stands
    wire [31:0] base_w  = rel_base_act ? actpos_r : last_tgt_r;
    wire [31:0] new_tgt = ctrl_smp_r[CB_REL] ? base_w + target_r
                                             : target_r;
    wire reachable = ($signed(new_tgt) >= $signed(limlo_r)) &
                     ($signed(new_tgt) <= $signed(limhi_r));
    wire queue_full = que_r.valid & ~immed;
    wire accept = in_mode & start_rise & reachable & ~queue_full
                  & ~stat_r[SB_ACK];
    wire at_tgt = (demand_r == act_r.target);
    wire [31:0] delta = act_r.target - demand_r;
    wire [31:0] ferr_abs = ferr_r[31] ? -ferr_r : ferr_r;

    // motion command path evaluated only on the tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_smp_r <= '0;
            ctrl_prev_r <= '0;
            in_mode_prev_r <= 1'b0;
            act_r <= '0;
            que_r <= '0;
            phase_r <= PH_IDLE;
            demand_r <= '0;
            last_tgt_r <= '0;
            stat_r <= '0;
            settle_r <= '0;
            ferr_cnt_r <= '0;
            self_clr_r <= 1'b0;
            ack_q_r <= 1'b0;
        end else begin
            self_clr_r <= 1'b0;
            if (tick_w) begin
                ctrl_smp_r <= ctrl_r;
                ctrl_prev_r <= ctrl_smp_r;
                in_mode_prev_r <= in_mode;
                // command acceptance
                if (accept) begin
                    last_tgt_r <= new_tgt;
                    if (immed | ~act_r.valid) begin
                        act_r <= '{1'b1, ctrl_smp_r[CB_PASS], new_tgt};
                        que_r.valid <= 1'b0;
                    end else begin
                        que_r <= '{1'b1, ctrl_smp_r[CB_PASS], new_tgt};
                    end
                    stat_r[SB_ACK] <= 1'b1;
                    ack_q_r <= act_r.valid & ~immed;
                    self_clr_r <= option_r[PO_AUTO0] | option_r[PO_AUTO1];
                end else if (~ctrl_smp_r[CB_START]) begin
                    stat_r[SB_ACK] <= 1'b0;
                end else if (stat_r[SB_ACK] & ack_q_r & ~que_r.valid) begin
                    stat_r[SB_ACK] <= 1'b0;
                end
                // demand set straight to the active target in one tick
                if (halt_on) begin
                    phase_r <= PH_HALT;
                end else if (act_r.valid & in_mode) begin
                    phase_r <= PH_MOVE;
                    if (!at_tgt)
                        demand_r <= act_r.target;
                    else if (que_r.valid) begin
                        // queued command taken over on arrival, whatever its pass bit
                        act_r <= que_r;
                        que_r.valid <= 1'b0;
                    end else begin
                        act_r.valid <= 1'b0;
                        phase_r <= PH_IDLE;
                    end
                end else begin
                    phase_r <= PH_IDLE;
                end
                // arrival with settle time, or halted standstill
                if (halt_on & (delta == 32'h0 | phase_r == PH_HALT))
                    stat_r[SB_REACH] <= 1'b1;
                else if (~act_r.valid & ~que_r.valid &
                         ($signed(actpos_r - last_tgt_r) <= $signed(window_r)) &
                         ($signed(last_tgt_r - actpos_r) <= $signed(window_r))) begin
                    if (settle_r >= SETTLE_TICKS[15:0])
                        stat_r[SB_REACH] <= 1'b1;
                    else
                        settle_r <= settle_r + 16'h0001;
                end else begin
                    settle_r <= '0;
                    stat_r[SB_REACH] <= 1'b0;
                end
                stat_r[SB_LIMIT] <= ($signed(demand_r) < $signed(limlo_r)) |
                                    ($signed(demand_r) > $signed(limhi_r));
                // following error held past its timeout; ferr_win_r stays at 32'hFFFFFFFF, so it never trips
                if (ferr_abs > ferr_win_r) begin
                    if (ferr_cnt_r >= FERR_TICKS[15:0])
                        stat_r[SB_FOLLOW] <= 1'b1;
                    else
                        ferr_cnt_r <= ferr_cnt_r + 16'h0001;
                end else begin
                    ferr_cnt_r <= '0;
                    stat_r[SB_FOLLOW] <= 1'b0;
                end
            end
        end
    end

endmodule : ppc_core

// >>> testbench/ppc_chk.sv
// Purpose: port-level assertions for the profile-position command block
// Assumes: one clock domain, resetn asynchronous and active low
// Notes:   strobe spacing is judged only after a first pulse has been seen
`timescale 1ns/100ps
module ppc_chk
    import ppc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // axi4-lite handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // strobes
    input wire logic        tick_1ms,
    input wire logic        cur_strobe,
    input wire logic        vel_strobe
);
    logic [15:0] tk_c, cu_c, ve_c;
    logic        tk_s, cu_s, ve_s;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // gap counters; the first pulse after reset has no reference
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {tk_c, cu_c, ve_c} <= '0;
            {tk_s, cu_s, ve_s} <= '0;
        end else begin
            tk_c <= tick_1ms ? 16'h0 : tk_c + 16'h1;
            cu_c <= cur_strobe ? 16'h0 : cu_c + 16'h1;
            ve_c <= vel_strobe ? 16'h0 : ve_c + 16'h1;
            tk_s <= tk_s | tick_1ms;
            cu_s <= cu_s | cur_strobe;
            ve_s <= ve_s | vel_strobe;
        end
    end

    a_tick_gap: assert property (
        tick_1ms && tk_s |-> tk_c == TICK_CYCLES - 1)
        else $error("tick spacing wrong");
    a_tick_pulse: assert property (tick_1ms |=> !tick_1ms)
        else $error("tick longer than one cycle");
    a_cur_gap: assert property (cur_strobe && cu_s |-> cu_c == 1561)
        else $error("current strobe spacing wrong");
    a_vel_gap: assert property (vel_strobe && ve_s |-> ve_c == 6249)
        else $error("velocity strobe spacing wrong");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("read response late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rerr_zero: assert property (s_axi_rvalid &&
        s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held too long");

    cover property (tick_1ms && tk_s);
    cover property (s_axi_bvalid && !s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : ppc_chk

bind ppc_core ppc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tick_1ms(tick_1ms),
    .cur_strobe(cur_strobe), .vel_strobe(vel_strobe));

// >>> testbench/ppc_host_bfm.sv
// Purpose: axi4-lite master standing in for the fieldbus host
// Assumes: one request at a time, started by a one-cycle go from the bench
// Notes:   slow holds bready/rready off until the answer shows, so the
//          slave must keep its response standing
`timescale 1ns/100ps
module ppc_host_bfm (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // bench request side
    input  wire logic        go,
    input  wire logic        we,
    input  wire logic        slow,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdat,
    output logic             done,
    output logic [31:0]      rdat,
    output logic [1:0]       resp,
    // axi4-lite master side
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    logic busy;

    assign wstrb = 4'hF;

    // released address and data lines show the inverse of their last value
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {awvalid, wvalid, bready, arvalid, rready, busy, done} <= '0;
            {awaddr, araddr, wdata, rdat, resp} <= '0;
        end else begin
            done <= 1'b0;
            if (!busy && go) begin
                busy    <= 1'b1;
                {awvalid, wvalid, arvalid} <= {we, we, !we};
                {awaddr, araddr, wdata} <= {addr, addr, wdat};
                bready  <= we && !slow;
                rready  <= !we && !slow;
            end else if (busy) begin
                if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
                if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
                if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
                if (bvalid && !bready) bready <= 1'b1;
                if (rvalid && !rready) rready <= 1'b1;
                if (bvalid && bready) begin
                    {bready, busy, done, resp} <= {3'b001, bresp};
                end
                if (rvalid && rready) begin
                    {rready, busy, done, resp} <= {3'b001, rresp};
                    rdat <= rdata;
                end
            end
        end
    end
endmodule : ppc_host_bfm

// >>> testbench/tb.sv
// Purpose: self-checking bench of the profile-position command block
// Assumes: short tick of 20 cycles so a run stays brief
// Notes:   expected demand comes from a small integer model of the targets
`timescale 1ns/100ps
module tb;
    import ppc_pkg::*;
    localparam int TK = 20;
    localparam logic [31:0] ST = 32'h1 << CB_START, IM = 32'h1 << CB_IMMED;
    localparam logic [31:0] RL = 32'h1 << CB_REL, MA = 32'h1 << SB_ACK;
    localparam logic [31:0] HL = 32'h1 << CB_HALT;
    localparam logic [31:0] MR = 32'h1 << SB_REACH, ML = 32'h1 << SB_LIMIT;
    logic clk = 1'b0, resetn = 1'b0, go = 1'b0, we = 1'b0, slow = 1'b0;
    logic [7:0]  addr = 8'h00, awaddr, araddr;
    logic [31:0] wdat = 32'h0, rd, rdat, wdata, rdata, seed = 32'h2BBF;
    logic [1:0]  rs, resp, bresp, rresp;
    logic [3:0]  wstrb;
    logic done, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tick, cur, vel;
    int miscompares = 0, n_tests = 0, t1, t2, m_last, m_dem;

    always #20 clk = ~clk;

    ppc_core #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tick_1ms(tick), .cur_strobe(cur),
        .vel_strobe(vel));

    ppc_host_bfm u_host (.clk(clk), .resetn(resetn), .go(go), .we(we),
        .slow(slow), .addr(addr), .wdat(wdat), .done(done), .rdat(rdat),
        .resp(resp), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic close_out();
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one bus transfer through the host model; random slow answers
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        we <= w;
        addr <= a;
        wdat <= d;
        slow <= (rnd() & 32'h1) != 32'h0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) miscompares++;
        rd = rdat;
        rs = resp;
        @(posedge clk);
    endtask : bus

    task automatic rdm(input string nm, input logic [7:0] a,
                       input logic [31:0] m, exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd & m, exp);
    endtask : rdm

    // status is only refreshed on the tick, so give it a few
    task automatic wt(input int n);
        repeat (n * TK) @(posedge clk);
    endtask : wt

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rdm("ctrl reset", OFF_CTRL, 32'hFFFF, {16'h0, CTRL_RST});
        rdm("unmapped rd", 8'h40, 32'hFFFFFFFF, 32'h0);
        chk("unmapped rd resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        bus(1'b1, OFF_STAT, 32'hFFFF);
        chk("ro wr resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        bus(1'b1, 8'h44, 32'h1);
        chk("unmapped wr resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        bus(1'b1, OFF_LIMLO, 32'h0);
        chk("wr resp", {30'h0, rs}, {30'h0, RESP_OKAY});
        bus(1'b1, OFF_LIMHI, 32'd1000);
        bus(1'b1, OFF_WINDOW, 32'd5);
        t1 = int'(rnd() % 400) + 1;
        t2 = int'(rnd() % 400) + 1;
        bus(1'b1, OFF_MODE, 32'h0);
        bus(1'b1, OFF_TARGET, t1);
        bus(1'b1, OFF_CTRL, ST | IM);
        wt(3);
        rdm("ack other mode", OFF_STAT, MA, 32'h0);
        bus(1'b1, OFF_MODE, {24'h0, MODE_PROFILE_POS});
        wt(3);
        m_last = t1;
        m_dem = t1;
        rdm("ack on entry", OFF_STAT, MA, MA);
        rdm("demand abs", OFF_DEMAND, 32'hFFFFFFFF, m_dem);
        bus(1'b1, OFF_CTRL, IM);
        wt(3);
        rdm("ack falls", OFF_STAT, MA, 32'h0);
        bus(1'b1, OFF_TARGET, t2);
        bus(1'b1, OFF_CTRL, ST | IM | RL);
        wt(3);
        m_dem = m_last + t2;
        rdm("ack relative", OFF_STAT, MA, MA);
        rdm("demand rel", OFF_DEMAND, 32'hFFFFFFFF, m_dem);
        bus(1'b1, OFF_CTRL, IM | RL);
        bus(1'b1, OFF_ACTPOS, m_dem);
        wt(8);
        rdm("reached", OFF_STAT, MR, MR);
        rdm("in limits", OFF_STAT, ML, 32'h0);
        bus(1'b1, OFF_LIMHI, m_dem - 1);
        wt(3);
        rdm("beyond limit", OFF_STAT, ML, ML);
        bus(1'b1, OFF_CTRL, HL | ST);
        wt(3);
        bus(1'b1, OFF_CTRL, HL);
        wt(3);
        bus(1'b1, OFF_CTRL, HL | ST);
        wt(3);
        rdm("ack queued", OFF_STAT, MA, MA);
        bus(1'b1, OFF_CTRL, ST);
        wt(4);
        rdm("ack drained", OFF_STAT, MA, 32'h0);
        rdm("demand queued", OFF_DEMAND, 32'hFFFFFFFF, t2);
        repeat (13000) @(posedge clk);
        close_out();
    end

    // hang guard, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule : tb
